// *** rtl/cbq_top.sv ***
/*
 * Buffer-ID queues between the host and the TDM side: a host-to-TDM
 * queue and two return queues, with levels, thresholds and interrupt.
 * Register map, byte offsets on reg_addr:
 *   0x54 host-to-TDM push (write, ID in bits 12:0)
 *   0x58 host-to-TDM level (read)
 *   0x5c host-to-TDM threshold (read/write)
 *   0x60 tx return pop (read, ID in bits 12:0, zero when empty)
 *   0x64 tx return level (read)
 *   0x68 tx return threshold (read/write)
 *   0x6c rx return pop (read, ID in bits 12:0, zero when empty)
 *   0x70 rx return level (read)
 *   0x74 rx return threshold (read/write)
 *   0x78 interrupt status, bit 0 host-to-TDM, 1 tx, 2 rx (write 1 clears)
 *   0x7c interrupt mask, same bits (read/write)
 *   0x80 tx return push from the host, for bring-up (write)
 *   0x84 rx return push from the host, for bring-up (write)
 * Unmapped reads answer zero and unmapped writes are ignored.
 * Limitations: a pop of an empty queue and a push into a full one are
 * dropped without a flag of their own; software sees only the level
 * and the threshold interrupt.
 * Assumes one 10 MHz clock, a single-cycle register port with strobes
 * of one cycle that never meet, and TDM-side logic that pops the first
 * queue and fills the return queues.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbq_defines.svh"

module cbq_top
    import cbq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [`CBQ_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // TDM side: consumes the host queue
    input wire logic tdm_pop,
    output logic [`CBQ_SD_ADDR_W-1:0] tdm_sd_addr,
    output logic [`CBQ_LVL_W-1:0] tdm_level,
    // TDM side: returns buffers
    input wire logic tx_ret_push,
    input wire logic [`CBQ_ID_W-1:0] tx_ret_id,
    input wire logic rx_ret_push,
    input wire logic [`CBQ_ID_W-1:0] rx_ret_id
);
    cbq_fifo_if q_tdm ();
    cbq_fifo_if q_tx ();
    cbq_fifo_if q_rx ();

    // per-queue thresholds, index 0 host-to-TDM, 1 tx, 2 rx
    cbq_lvl_t thr_ff [3];
    cbq_lvl_t nxt_thr [3];
    // interrupt state, one bit per queue
    logic [`CBQ_IRQ_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask, evt;
    logic [`CBQ_IRQ_W-1:0] clr;
    logic irq_ff, nxt_irq;
    // registered answers towards the host and the TDM side
    logic [31:0] hold_ff, nxt_hold;
    logic [`CBQ_SD_ADDR_W-1:0] sd_ff, nxt_sd;
    // decoded one-cycle strobes of the register port
    logic wr_tdm_push, wr_tx_push, wr_rx_push;
    logic wr_tdm_thr, wr_tx_thr, wr_rx_thr;
    logic wr_stat, wr_mask;
    logic rd_tx_pop, rd_rx_pop;

    // id placed as the top bits of an SDRAM address
    function automatic logic [`CBQ_SD_ADDR_W-1:0] id_to_sd(input cbq_id_t id);
        id_to_sd = {id, {`CBQ_SD_LOW_W{1'b0}}};
    endfunction : id_to_sd

    function automatic logic [31:0] zx6(input cbq_lvl_t v);
        zx6 = {26'h000_0000, v};
    endfunction : zx6

    // a buffer ID in the low bits of a read word
    function automatic logic [31:0] zx13(input cbq_id_t v);
        zx13 = {19'h0_0000, v};
    endfunction : zx13

    // a strobe aimed at one register offset
    function automatic logic hit(input logic strobe,
                                 input logic [`CBQ_ADDR_W-1:0] addr,
                                 input logic [`CBQ_ADDR_W-1:0] off);
        hit = strobe && (addr == off);
    endfunction : hit

    // ***************************************************************
    // queues
    // ***************************************************************
    // host-to-TDM queue, drained by the TDM side
    cbq_fifo u_tdm
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .q(q_tdm)
    );

    // tx return queue, drained by host reads
    cbq_fifo u_tx
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .q(q_tx)
    );

    // rx return queue, drained by host reads
    cbq_fifo u_rx
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .q(q_rx)
    );

    // ***************************************************************
    // register port decode
    // ***************************************************************
    // reads and writes share one address, so every strobe is qualified
    assign wr_tdm_push = hit(reg_wr, reg_addr, `CBQ_OFF_TDM_PUSH);
    assign wr_tx_push = hit(reg_wr, reg_addr, `CBQ_OFF_TX_PUSH);
    assign wr_rx_push = hit(reg_wr, reg_addr, `CBQ_OFF_RX_PUSH);
    assign wr_tdm_thr = hit(reg_wr, reg_addr, `CBQ_OFF_TDM_ALARM);
    assign wr_tx_thr = hit(reg_wr, reg_addr, `CBQ_OFF_TX_ALARM);
    assign wr_rx_thr = hit(reg_wr, reg_addr, `CBQ_OFF_RX_ALARM);
    assign wr_stat = hit(reg_wr, reg_addr, `CBQ_OFF_IRQ_STAT);
    assign wr_mask = hit(reg_wr, reg_addr, `CBQ_OFF_IRQ_MASK);
    assign rd_tx_pop = hit(reg_rd, reg_addr, `CBQ_OFF_TX_POP);
    assign rd_rx_pop = hit(reg_rd, reg_addr, `CBQ_OFF_RX_POP);

    // ***************************************************************
    // queue inputs
    // ***************************************************************
    // host pushes only low 13 bits; upper bits ignored
    assign q_tdm.push = wr_tdm_push;
    assign q_tdm.push_id = reg_wdata[`CBQ_ID_W-1:0];
    assign q_tdm.pop = tdm_pop;
    // return queues filled from the TDM side, or by host for bring-up;
    // on a clash the TDM side wins and the host ID is lost
    assign q_tx.push = tx_ret_push || wr_tx_push;
    assign q_tx.push_id = tx_ret_push ? tx_ret_id
                                      : reg_wdata[`CBQ_ID_W-1:0];
    assign q_tx.pop = rd_tx_pop;
    assign q_rx.push = rx_ret_push || wr_rx_push;
    assign q_rx.push_id = rx_ret_push ? rx_ret_id
                                      : reg_wdata[`CBQ_ID_W-1:0];
    assign q_rx.pop = rd_rx_pop;

    // ***************************************************************
    // thresholds
    // ***************************************************************
    // only the low six bits are kept; a threshold above 32 never fires
    always_comb
    begin
        nxt_thr = thr_ff;
        if (wr_tdm_thr)
            nxt_thr[0] = reg_wdata[`CBQ_LVL_W-1:0];
        if (wr_tx_thr)
            nxt_thr[1] = reg_wdata[`CBQ_LVL_W-1:0];
        if (wr_rx_thr)
            nxt_thr[2] = reg_wdata[`CBQ_LVL_W-1:0];
    end

    // registered copy only
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            thr_ff[0] <= `CBQ_THR_RST;
            thr_ff[1] <= `CBQ_THR_RST;
            thr_ff[2] <= `CBQ_THR_RST;
        end
        else
        begin
            thr_ff <= nxt_thr;
        end
    end

    // ***************************************************************
    // interrupt mask
    // ***************************************************************
    // plain read/write register, same bit layout as the status
    always_comb
    begin
        nxt_mask = mask_ff;
        if (wr_mask)
            nxt_mask = reg_wdata[`CBQ_IRQ_W-1:0];
    end

    // registered copy only
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            mask_ff <= `CBQ_MASK_RST;
        else
            mask_ff <= nxt_mask;
    end

    // ***************************************************************
    // interrupt status and request
    // ***************************************************************
    // threshold events are levels, so a bit re-arms at once while the
    // queue stays at or past its threshold; a set in the clearing
    // cycle wins so that no event slips between read and clear
    always_comb
    begin
        evt[0] = q_tdm.level >= thr_ff[0];
        evt[1] = q_tx.level >= thr_ff[1];
        evt[2] = q_rx.level >= thr_ff[2];
        clr = wr_stat ? reg_wdata[`CBQ_IRQ_W-1:0] : {`CBQ_IRQ_W{1'b0}};
        nxt_stat = (stat_ff & ~clr) | evt;
        // the request follows the same edge as the status it reflects
        nxt_irq = |(nxt_stat & nxt_mask);
    end

    // registered copies only; the request output is a flop
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stat_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            stat_ff <= nxt_stat;
            irq_ff <= nxt_irq;
        end
    end

    // ***************************************************************
    // read path
    // ***************************************************************
    // everything a read returns is captured at the strobe edge, so the
    // data stand in the next cycle straight from hold_ff; a pop takes
    // the queue's prefetched head, which the same edge then advances
    always_comb
    begin
        case (reg_addr)
            `CBQ_OFF_TDM_FILL: nxt_hold = zx6(q_tdm.level);
            `CBQ_OFF_TDM_ALARM: nxt_hold = zx6(thr_ff[0]);
            `CBQ_OFF_TX_POP: nxt_hold = zx13(q_tx.pop_id);
            `CBQ_OFF_TX_FILL: nxt_hold = zx6(q_tx.level);
            `CBQ_OFF_TX_ALARM: nxt_hold = zx6(thr_ff[1]);
            `CBQ_OFF_RX_POP: nxt_hold = zx13(q_rx.pop_id);
            `CBQ_OFF_RX_FILL: nxt_hold = zx6(q_rx.level);
            `CBQ_OFF_RX_ALARM: nxt_hold = zx6(thr_ff[2]);
            `CBQ_OFF_IRQ_STAT: nxt_hold = {29'h0000_0000, stat_ff};
            `CBQ_OFF_IRQ_MASK: nxt_hold = {29'h0000_0000, mask_ff};
            default: nxt_hold = 32'h0000_0000;
        endcase
        // data stand for one cycle only; otherwise the port reads zero
        if (!reg_rd)
            nxt_hold = 32'h0000_0000;
    end

    // registered copy only; drives the read data port directly
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            hold_ff <= '0;
        else
            hold_ff <= nxt_hold;
    end

    // ***************************************************************
    // TDM-side head address
    // ***************************************************************
    // the address of the ID taken by the last pop stands until the next
    // pop; an empty queue has a zero head, so its pop gives address zero
    always_comb
    begin
        nxt_sd = sd_ff;
        if (tdm_pop)
            nxt_sd = id_to_sd(q_tdm.pop_id);
    end

    // registered copy only
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            sd_ff <= '0;
        else
            sd_ff <= nxt_sd;
    end

    // ***************************************************************
    // outputs, each straight from a register
    // ***************************************************************
    assign reg_rdata = hold_ff;
    assign tdm_sd_addr = sd_ff;
    // the level register lives in the queue itself
    assign tdm_level = q_tdm.level;
    assign irq = irq_ff;
endmodule : cbq_top

`default_nettype wire

// *** rtl/cbq_defines.svh ***
/*
 * Register offsets, field positions, reset values and sizes of the
 * buffer-ID queue block. Included by the package and the modules.
 */
`ifndef CBQ_DEFINES_SVH
`define CBQ_DEFINES_SVH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define CBQ_ADDR_W 8
`define CBQ_OFF_TDM_PUSH 8'h54
`define CBQ_OFF_TDM_FILL 8'h58
`define CBQ_OFF_TDM_ALARM 8'h5c
`define CBQ_OFF_TX_POP 8'h60
`define CBQ_OFF_TX_FILL 8'h64
`define CBQ_OFF_TX_ALARM 8'h68
`define CBQ_OFF_RX_POP 8'h6c
`define CBQ_OFF_RX_FILL 8'h70
`define CBQ_OFF_RX_ALARM 8'h74
`define CBQ_OFF_IRQ_STAT 8'h78
`define CBQ_OFF_IRQ_MASK 8'h7c
`define CBQ_OFF_TX_PUSH 8'h80
`define CBQ_OFF_RX_PUSH 8'h84

// ***************************************************************
// fields and sizes
// ***************************************************************
`define CBQ_ID_W 13
`define CBQ_LVL_W 6
`define CBQ_DEPTH 32
`define CBQ_PTR_W 5
`define CBQ_SD_ADDR_W 24
`define CBQ_SD_LOW_W 11
`define CBQ_IRQ_W 3
`define CBQ_LVL_RST 6'h00
`define CBQ_THR_RST 6'h00
`define CBQ_MASK_RST 3'h0
`define CBQ_FULL_LVL 6'h20

`endif

// *** rtl/cbq_pkg.sv ***
/*
 * Types of the buffer-ID queue block.
 * Assumes cbq_defines.svh is on the include path.
 */
`include "cbq_defines.svh"

package cbq_pkg;
    typedef logic [`CBQ_ID_W-1:0] cbq_id_t;
    typedef logic [`CBQ_LVL_W-1:0] cbq_lvl_t;
    typedef enum logic [1:0] {CBQ_Q_TDM, CBQ_Q_TX, CBQ_Q_RX} cbq_qsel_e;
endpackage : cbq_pkg

// *** rtl/cbq_fifo_if.sv ***
/*
 * Push/pop carrier between the register front end and one queue.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbq_defines.svh"

interface cbq_fifo_if;
    logic push;
    logic [`CBQ_ID_W-1:0] push_id;
    logic pop;
    logic [`CBQ_ID_W-1:0] pop_id;
    logic [`CBQ_LVL_W-1:0] level;
    modport ctl (output push, output push_id, output pop,
                 input pop_id, input level);
    modport mem (input push, input push_id, input pop,
                 output pop_id, output level);
endinterface : cbq_fifo_if

`default_nettype wire

// *** rtl/cbq_fifo.sv ***
/*
 * 32-deep queue of 13-bit buffer IDs; the head comes out of a register.
 * Assumes one clock; pushes into a full queue and pops of an empty one
 * are dropped, and the head register shows zero while empty.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbq_defines.svh"

module cbq_fifo
    import cbq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    cbq_fifo_if.mem q
);
    cbq_id_t mem_ff [`CBQ_DEPTH];
    logic [`CBQ_PTR_W-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    cbq_lvl_t lvl_ff, nxt_lvl;
    cbq_id_t head_ff, nxt_head;
    logic do_push, do_pop;

    // ***************************************************************
    // pointer and level update
    // ***************************************************************
    always_comb
    begin
        do_push = q.push && (lvl_ff != `CBQ_FULL_LVL);
        do_pop = q.pop && (lvl_ff != `CBQ_LVL_RST);
        nxt_wr = do_push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = do_pop ? rd_ff + 1'b1 : rd_ff;
        nxt_lvl = lvl_ff + {5'h00, do_push} - {5'h00, do_pop};
        // the head register always holds the oldest entry, zero when
        // empty, so a pop is answered from a register with no extra cycle
        nxt_head = head_ff;
        if (do_pop)
            nxt_head = (lvl_ff > 6'h01) ? mem_ff[nxt_rd] : '0;
        if (do_push && (lvl_ff == `CBQ_LVL_RST
                        || (do_pop && lvl_ff == 6'h01)))
            nxt_head = q.push_id;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            lvl_ff <= `CBQ_LVL_RST;
            head_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            lvl_ff <= nxt_lvl;
            head_ff <= nxt_head;
        end
    end

    // storage has no reset; contents are meaningless until pushed
    always_ff @(posedge sys_clk)
    begin
        if (do_push)
            mem_ff[wr_ff] <= q.push_id;
    end

    assign q.pop_id = head_ff;
    assign q.level = lvl_ff;
endmodule : cbq_fifo

`default_nettype wire

// *** dv/cbq_properties.sv ***
/*
 * port checker of the buffer-id queue block.
 * assumes one clock and the bind below onto cbq_top.
 */
`timescale 1ns/1ps
`default_nettype none

module cbq_properties (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic tdm_pop,
    input wire logic [23:0] tdm_sd_addr,
    input wire logic [5:0] tdm_level,
    input wire logic tx_ret_push,
    input wire logic [12:0] tx_ret_id,
    input wire logic rx_ret_push,
    input wire logic [12:0] rx_ret_id
);
    // ****************************************************
    // properties
    // ****************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // read data only in the cycle after a strobe
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    rdata_upper_a: assert property (reg_rd |=> reg_rdata[31:13] == '0)
        else $error("reserved read bits set");
    level_range_a: assert property (tdm_level <= 6'h20)
        else $error("level above 32");
    // a push grows the level by one unless the queue is full
    push_level_a: assert property (reg_wr && reg_addr == 8'h54 && !tdm_pop
        && tdm_level < 6'h20 |=> tdm_level == $past(tdm_level) + 6'h01)
        else $error("push not counted");
    full_drop_a: assert property (reg_wr && reg_addr == 8'h54 && !tdm_pop
        && tdm_level == 6'h20 |=> tdm_level == 6'h20)
        else $error("push to full queue counted");
    pop_level_a: assert property (tdm_pop && !(reg_wr && reg_addr == 8'h54)
        && tdm_level != '0 |=> tdm_level == $past(tdm_level) - 6'h01)
        else $error("pop not counted");
    sd_low_a: assert property (tdm_sd_addr[10:0] == 11'h000)
        else $error("address low bits not zero");
    sd_hold_a: assert property (!tdm_pop |=> $stable(tdm_sd_addr))
        else $error("address moved without pop");
    empty_pop_a: assert property (tdm_pop && tdm_level == '0
        |=> tdm_sd_addr == 24'h00_0000)
        else $error("empty pop gave an address");
endmodule : cbq_properties

bind cbq_top cbq_properties u_cbq_properties (.sys_clk, .arst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .tdm_pop,
    .tdm_sd_addr, .tdm_level, .tx_ret_push, .tx_ret_id, .rx_ret_push,
    .rx_ret_id);

`default_nettype wire

// *** dv/cbq_top_test.sv ***
/*
 * self-checking bench of cbq_top against a queue model.
 * assumes the checker file is compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module cbq_top_test;
    // ****************************************************
    // stimulus, model and checks
    // ****************************************************
    logic sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, tdm_pop = 0;
    logic tx_ret_push = 0, rx_ret_push = 0, irq;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [12:0] tx_ret_id = 0, rx_ret_id = 0;
    logic [23:0] tdm_sd_addr;
    logic [5:0] tdm_level;
    logic [12:0] mq[3][$];
    int thr[3] = '{0, 0, 0};
    logic [2:0] stat = 0, mask = 0;
    int error_cnt = 0, checked = 0, cyc = 0;
    logic [15:0] rnd = 16'h0060;
    logic [7:0] offs[10] = '{8'h58, 8'h5c, 8'h64, 8'h68, 8'h70, 8'h74,
        8'h60, 8'h6c, 8'h78, 8'h40};

    cbq_top u_cbq_top (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .tdm_pop, .tdm_sd_addr, .tdm_level,
        .tx_ret_push, .tx_ret_id, .rx_ret_push, .rx_ret_id);

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic print_verdict;
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // status is set each cycle the level reaches its threshold
    always @(negedge sys_clk)
        for (int k = 0; k < 3; k++)
            if (arst_n && mq[k].size() >= thr[k])
                stat[k] = 1'b1;

    // hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            print_verdict;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        k = (a == 8'h54) ? 0 : (a - 8'h7c) / 4;
        case (a)
            8'h54, 8'h80, 8'h84: if (mq[k].size() < 32) mq[k].push_back(d);
            8'h5c, 8'h68, 8'h74: thr[(a - 8'h5c) / 12] = d[5:0];
            8'h78: stat = stat & ~d[2:0];
            8'h7c: mask = d[2:0];
            default: ;
        endcase
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        int k;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        e = '0;
        k = (a - 8'h60) / 12 + 1;
        case (a)
            8'h58, 8'h64, 8'h70: e = mq[(a - 8'h58) / 12].size();
            8'h5c, 8'h68, 8'h74: e = thr[(a - 8'h5c) / 12];
            8'h60, 8'h6c: if (mq[k].size() > 0) e = mq[k].pop_front();
            8'h78: e = stat;
            8'h7c: e = mask;
            default: e = '0;
        endcase
        @(negedge sys_clk);
        chk("reg_rdata", reg_rdata, e);
        chk("irq", irq, |(stat & mask));
        @(posedge sys_clk);
    endtask : rd

    task automatic tpop;
        logic [23:0] e;
        tdm_pop <= 1'b1;
        @(posedge sys_clk);
        tdm_pop <= 1'b0;
        e = '0;
        if (mq[0].size() > 0) e = {mq[0].pop_front(), 11'h000};
        @(negedge sys_clk);
        chk("tdm_sd_addr", tdm_sd_addr, e);
        chk("tdm_level", tdm_level, mq[0].size());
        @(posedge sys_clk);
    endtask : tpop

    initial
    begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (offs[i]) rd(offs[i]);
        wr(8'h7c, 32'h0000_0007);
        rd(8'h78);
        wr(8'h5c, 32'h0000_0020);
        wr(8'h68, 32'h0000_0003);
        wr(8'h74, 32'h0000_0002);
        wr(8'h78, 32'h0000_0007);
        rd(8'h78);
        rd(8'h5c);
        rd(8'h68);
        rd(8'h74);
        rd(8'h7c);
        // one push beyond full; upper bits kept zero by software
        repeat (33)
        begin
            rnd = lfsr(rnd);
            wr(8'h54, {19'h0_0000, rnd[12:0]});
        end
        rd(8'h58);
        rd(8'h78);
        repeat (33) tpop;
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            tx_ret_push <= 1'b1;
            tx_ret_id <= rnd[12:0];
            rx_ret_push <= i[0];
            rx_ret_id <= rnd[15:3];
            @(posedge sys_clk);
            tx_ret_push <= 1'b0;
            rx_ret_push <= 1'b0;
            mq[1].push_back(rnd[12:0]);
            if (i[0]) mq[2].push_back(rnd[15:3]);
            @(posedge sys_clk);
        end
        wr(8'h80, 32'h0000_1fff);
        wr(8'h84, 32'h0000_0abc);
        rd(8'h64);
        rd(8'h70);
        rd(8'h78);
        // a clear while the level still meets the threshold is lost
        wr(8'h78, 32'h0000_0007);
        rd(8'h78);
        repeat (8)
        begin
            rd(8'h60);
            rd(8'h6c);
        end
        print_verdict;
    end
endmodule : cbq_top_test

`default_nettype wire
